// [rtl/cecs_pkg.sv]
// event selection and counting package: codes, masks, widths, carriers
// assumes every occurrence input comes from core logic on the same clock
// What this block does
// [RULE1] code 0CH mask 02H counts each core cycle spent in a page walk
// [RULE2] code 10H mask 00H counts float compute micro-ops, first counter only
// [RULE3] code 11H mask 00H counts float ops needing microcode assist, second only
// [RULE4] vector assist: denormal input without denormals-as-zero, underflow without flush-to-zero
// [RULE5] stack assist: NaN/denormal load or memory input, divide by zero, underflow
// [RULE6] code 12H mask 00H counts integer and float multiplies, second only
// [RULE7] code 13H mask 00H counts divides and square roots, second only
// [RULE8] code 14H mask 00H counts divider busy cycles, first counter only
// [RULE9] code 18H counts divider busy with all else idle, first only
// [RULE10] divider-only: ignore micro-ops dispatched before divider start, loads hit L1
// [RULE11] code 19H mask 00H counts float bypass penalties from other units, second only
// [RULE12] code 19H mask 01H counts vector bypass penalties, second counter only
// [RULE13] add all occurrences each cycle; unsupported code and mask pair counts nothing
package cecs_pkg;
   localparam int CECS_CNT_W  = 40;
   localparam int CECS_INC_W  = 3;
   localparam int CECS_UNITS  = 4;
   localparam int CECS_LOAD_W = 2;
   // loads are assumed to hit the first-level data cache, so they finish in fixed time
   localparam logic [CECS_LOAD_W-1:0] CECS_LOAD_HIT_CYCLES = 2'h3;

   localparam logic [7:0] CECS_CODE_PAGE_WALK = 8'h0c;
   localparam logic [7:0] CECS_CODE_FP_UOP    = 8'h10;
   localparam logic [7:0] CECS_CODE_ASSIST    = 8'h11;
   localparam logic [7:0] CECS_CODE_MUL       = 8'h12;
   localparam logic [7:0] CECS_CODE_DIV       = 8'h13;
   localparam logic [7:0] CECS_CODE_DIV_BUSY  = 8'h14;
   localparam logic [7:0] CECS_CODE_DIV_IDLE  = 8'h18;
   localparam logic [7:0] CECS_CODE_BYPASS    = 8'h19;
   localparam logic [7:0] CECS_MASK_ZERO      = 8'h00;
   localparam logic [7:0] CECS_MASK_SIMD      = 8'h01;
   localparam logic [7:0] CECS_MASK_CYCLES    = 8'h02;

   localparam logic [CECS_CNT_W-1:0] CECS_CNT_RESET = 40'h00_0000_0000;

   typedef enum logic [3:0] {
      CECS_EVT_NONE      = 4'h0,
      CECS_EVT_PAGE_WALK = 4'h1,
      CECS_EVT_FP_UOP    = 4'h2,
      CECS_EVT_ASSIST    = 4'h3,
      CECS_EVT_MUL       = 4'h4,
      CECS_EVT_DIV       = 4'h5,
      CECS_EVT_DIV_BUSY  = 4'h6,
      CECS_EVT_DIV_IDLE  = 4'h7,
      CECS_EVT_FP_BYP    = 4'h8,
      CECS_EVT_SIMD_BYP  = 4'h9
   } cecs_evt_e;

   typedef struct packed {
      logic [7:0] code;
      logic [7:0] umask;
   } cecs_sel_s;

   typedef struct packed {
      logic vec_valid;
      logic vec_denormal_in;
      logic vec_underflow;
      logic denormals_as_zero_flag;
      logic flush_underflow_to_zero_flag;
      logic stk_nan_denormal_load;
      logic stk_div_by_zero;
      logic stk_underflow;
   } cecs_assist_s;

   typedef struct packed {
      logic [CECS_INC_W-1:0] page_walk;
      logic [CECS_INC_W-1:0] float_compute_uop_event;
      logic [CECS_INC_W-1:0] float_assist_event;
      logic [CECS_INC_W-1:0] multiply_event;
      logic [CECS_INC_W-1:0] divide;
      logic [CECS_INC_W-1:0] div_busy;
      logic [CECS_INC_W-1:0] div_only;
      logic [CECS_INC_W-1:0] float_bypass_penalty_event;
      logic [CECS_INC_W-1:0] vector_bypass_penalty_event;
   } cecs_occ_s;
endpackage

// [rtl/cecs_event_mux.sv]
// picks one counter's per-cycle increment from the occurrence bundle
// assumes the selection is stable while counting; purely combinational
`timescale 1ns/1ps
module cecs_event_mux
   import cecs_pkg::*;
#(
   parameter int CTR_ID = 0
) (
   input  cecs_sel_s             sel,
   input  cecs_occ_s             occ,
   output logic [CECS_INC_W-1:0] incr,
   output logic                  supported
);
   // decoding shared by both counter instances lives here once
   function automatic cecs_evt_e evt_decode(input cecs_sel_s s);
      cecs_evt_e e;
      e = CECS_EVT_NONE;
      if (s.code == CECS_CODE_PAGE_WALK && s.umask == CECS_MASK_CYCLES) begin
         e = CECS_EVT_PAGE_WALK;
      end else if (s.code == CECS_CODE_FP_UOP && s.umask == CECS_MASK_ZERO) begin
         e = CECS_EVT_FP_UOP;
      end else if (s.code == CECS_CODE_ASSIST && s.umask == CECS_MASK_ZERO) begin
         e = CECS_EVT_ASSIST;
      end else if (s.code == CECS_CODE_MUL && s.umask == CECS_MASK_ZERO) begin
         e = CECS_EVT_MUL;
      end else if (s.code == CECS_CODE_DIV && s.umask == CECS_MASK_ZERO) begin
         e = CECS_EVT_DIV;
      end else if (s.code == CECS_CODE_DIV_BUSY && s.umask == CECS_MASK_ZERO) begin
         e = CECS_EVT_DIV_BUSY;
      end else if (s.code == CECS_CODE_DIV_IDLE && s.umask == CECS_MASK_ZERO) begin
         e = CECS_EVT_DIV_IDLE;
      end else if (s.code == CECS_CODE_BYPASS && s.umask == CECS_MASK_ZERO) begin
         e = CECS_EVT_FP_BYP;
      end else if (s.code == CECS_CODE_BYPASS && s.umask == CECS_MASK_SIMD) begin
         e = CECS_EVT_SIMD_BYP;
      end
      return e;
   endfunction

   // some events exist on only one of the two general counters
   function automatic logic evt_allowed(input cecs_evt_e e, input int ctr);
      logic ok;
      ok = 1'b0;
      case (e)
         CECS_EVT_PAGE_WALK: ok = 1'b1;
         CECS_EVT_FP_UOP:    ok = (ctr == 0);   // see [RULE2]
         CECS_EVT_ASSIST:    ok = (ctr == 1);   // see [RULE3]
         CECS_EVT_MUL:       ok = (ctr == 1);   // see [RULE6]
         CECS_EVT_DIV:       ok = (ctr == 1);   // see [RULE7]
         CECS_EVT_DIV_BUSY:  ok = (ctr == 0);   // see [RULE8]
         CECS_EVT_DIV_IDLE:  ok = (ctr == 0);   // see [RULE9]
         CECS_EVT_FP_BYP:    ok = (ctr == 1);   // see [RULE11]
         CECS_EVT_SIMD_BYP:  ok = (ctr == 1);   // see [RULE12]
         default:            ok = 1'b0;
      endcase
      return ok;
   endfunction

   cecs_evt_e evt;

   always_comb begin
      evt       = evt_decode(sel);
      supported = evt_allowed(evt, CTR_ID);
      incr      = '0;
      if (supported) begin
         case (evt)
            CECS_EVT_PAGE_WALK: incr = occ.page_walk;                    // see [RULE1]
            CECS_EVT_FP_UOP:    incr = occ.float_compute_uop_event;      // see [RULE2]
            CECS_EVT_ASSIST:    incr = occ.float_assist_event;           // see [RULE3]
            CECS_EVT_MUL:       incr = occ.multiply_event;               // see [RULE6]
            CECS_EVT_DIV:       incr = occ.divide;                       // see [RULE7]
            CECS_EVT_DIV_BUSY:  incr = occ.div_busy;                     // see [RULE8]
            CECS_EVT_DIV_IDLE:  incr = occ.div_only;                     // see [RULE9]
            CECS_EVT_FP_BYP:    incr = occ.float_bypass_penalty_event;   // see [RULE11]
            CECS_EVT_SIMD_BYP:  incr = occ.vector_bypass_penalty_event;  // see [RULE12]
            default:            incr = '0;                               // see [RULE13]
         endcase
      end
   end
endmodule

// [rtl/cecs_top.sv]
// two general counters fed by the event selection and occurrence logic
// assumes all occurrence inputs are reported by core units on CLK, one report per cycle
// assumes divider busy is a level and unit dispatch and done are single-cycle pulses
`timescale 1ns/1ps
module cecs_top
   import cecs_pkg::*;
(
   input  wire logic                  CLK,
   input  wire logic                  RESET,
   input  wire cecs_sel_s             SELECT0,
   input  wire cecs_sel_s             SELECT1,
   input  wire logic [1:0]            COUNT_ENABLE,
   input  wire logic [1:0]            COUNT_CLEAR,
   input  wire logic                  PAGE_WALK_ACTIVE,
   input  wire logic [CECS_INC_W-1:0] FP_UOP_EXECUTED,
   input  wire cecs_assist_s          ASSIST,
   input  wire logic [CECS_INC_W-1:0] MUL_EXECUTED,
   input  wire logic [CECS_INC_W-1:0] DIV_EXECUTED,
   input  wire logic                  DIV_BUSY,
   input  wire logic [CECS_UNITS-1:0] UNIT_DISPATCH,
   input  wire logic [CECS_UNITS-1:0] UNIT_DONE,
   input  wire logic                  LOAD_DISPATCH,
   input  wire logic [CECS_INC_W-1:0] FP_BYPASS_PENALTY,
   input  wire logic [CECS_INC_W-1:0] SIMD_BYPASS_PENALTY,
   output logic [CECS_CNT_W-1:0]      COUNT0,
   output logic [CECS_CNT_W-1:0]      COUNT1,
   output logic [1:0]                 SELECT_SUPPORTED
);
   typedef struct packed {
      logic [CECS_CNT_W-1:0]  cnt0;
      logic [CECS_CNT_W-1:0]  cnt1;
      logic [1:0]             supported;
      logic [CECS_UNITS-1:0]  unit_inflight;
      logic [CECS_LOAD_W-1:0] load_left;
   } cecs_state_s;

   cecs_state_s           state_reg;
   cecs_state_s           state_next;
   cecs_occ_s             occ;
   logic [CECS_INC_W-1:0] incr0;
   logic [CECS_INC_W-1:0] incr1;
   logic                  sup0;
   logic                  sup1;
   logic [CECS_UNITS-1:0] inflight_next;
   logic                  vec_assist;
   logic                  stk_assist;
   logic                  others_active;

   // a unit is tracked only if its micro-op went out while the divider was running;
   // older work is ignored on purpose, so a long op issued before the divide does
   // not hide idle cycles
   genvar u;
   generate
      for (u = 0; u < CECS_UNITS; u++) begin : g_unit
         always_comb begin
            if (!DIV_BUSY) begin
               inflight_next[u] = 1'b0;
            end else if (UNIT_DISPATCH[u]) begin
               // dispatch beats a same-cycle done so the new micro-op is not lost
               inflight_next[u] = 1'b1;                               // see [RULE10]
            end else if (UNIT_DONE[u]) begin
               inflight_next[u] = 1'b0;
            end else begin
               inflight_next[u] = state_reg.unit_inflight[u];
            end
         end
      end
   endgenerate

   always_comb begin
      // one assist per instruction even if several conditions hold
      vec_assist = ASSIST.vec_valid &&
                   ((ASSIST.vec_denormal_in && !ASSIST.denormals_as_zero_flag) ||
                    (ASSIST.vec_underflow && !ASSIST.flush_underflow_to_zero_flag)); // see [RULE4]
      stk_assist = ASSIST.stk_nan_denormal_load || ASSIST.stk_div_by_zero ||
                   ASSIST.stk_underflow;                               // see [RULE5]

      // a load dispatched during the divide keeps the machine busy for a fixed hit time
      others_active = (|state_reg.unit_inflight) || (|(UNIT_DISPATCH & {CECS_UNITS{DIV_BUSY}})) ||
                      (state_reg.load_left != '0) || (LOAD_DISPATCH && DIV_BUSY); // see [RULE10]

      occ                             = '0;
      occ.page_walk                   = {{(CECS_INC_W-1){1'b0}}, PAGE_WALK_ACTIVE}; // see [RULE1]
      occ.float_compute_uop_event     = FP_UOP_EXECUTED;                            // see [RULE2]
      occ.float_assist_event          = CECS_INC_W'({1'b0, vec_assist} +
                                                    {1'b0, stk_assist});            // see [RULE3]
      occ.multiply_event              = MUL_EXECUTED;                               // see [RULE6]
      occ.divide                      = DIV_EXECUTED;                               // see [RULE7]
      occ.div_busy                    = {{(CECS_INC_W-1){1'b0}}, DIV_BUSY};         // see [RULE8]
      occ.div_only                    = {{(CECS_INC_W-1){1'b0}},
                                         DIV_BUSY && !others_active};               // see [RULE9]
      // each bypass case costs exactly one penalty cycle, so cases and cycles agree
      occ.float_bypass_penalty_event  = FP_BYPASS_PENALTY;                          // see [RULE11]
      occ.vector_bypass_penalty_event = SIMD_BYPASS_PENALTY;                        // see [RULE12]
   end

   cecs_event_mux #(
      .CTR_ID (0)
   ) u_mux0 (
      .sel       (SELECT0),
      .occ       (occ),
      .incr      (incr0),
      .supported (sup0)
   );

   cecs_event_mux #(
      .CTR_ID (1)
   ) u_mux1 (
      .sel       (SELECT1),
      .occ       (occ),
      .incr      (incr1),
      .supported (sup1)
   );

   always_comb begin
      state_next               = state_reg;
      state_next.supported     = {sup1, sup0};
      state_next.unit_inflight = inflight_next;

      if (!DIV_BUSY) begin
         state_next.load_left = '0;
      end else if (LOAD_DISPATCH) begin
         state_next.load_left = CECS_LOAD_HIT_CYCLES;                  // see [RULE10]
      end else if (state_reg.load_left != '0) begin
         state_next.load_left = state_reg.load_left - 1'b1;
      end

      // clear wins over a same-cycle increment; counters wrap silently
      if (COUNT_CLEAR[0]) begin
         state_next.cnt0 = CECS_CNT_RESET;
      end else if (COUNT_ENABLE[0]) begin
         state_next.cnt0 = state_reg.cnt0 + CECS_CNT_W'(incr0);        // see [RULE13]
      end

      if (COUNT_CLEAR[1]) begin
         state_next.cnt1 = CECS_CNT_RESET;
      end else if (COUNT_ENABLE[1]) begin
         state_next.cnt1 = state_reg.cnt1 + CECS_CNT_W'(incr1);        // see [RULE13]
      end
   end

   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         state_reg.cnt0          <= CECS_CNT_RESET;
         state_reg.cnt1          <= CECS_CNT_RESET;
         state_reg.supported     <= 2'h0;
         state_reg.unit_inflight <= '0;
         state_reg.load_left     <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign COUNT0           = state_reg.cnt0;
   assign COUNT1           = state_reg.cnt1;
   assign SELECT_SUPPORTED = state_reg.supported;
endmodule

// [testbench/cecs_core_model.sv]
// behavioural model of the core units that report occurrences to the counters
// assumes one clock; all reports change just after the rising edge
`timescale 1ns/1ps
module cecs_core_model
   import cecs_pkg::*;
(
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic [31:0]      rnd,
   output logic                  page_walk,
   output logic [CECS_INC_W-1:0] fp_uop,
   output cecs_assist_s          assist,
   output logic [CECS_INC_W-1:0] mul,
   output logic [CECS_INC_W-1:0] div,
   output logic                  div_busy,
   output logic [CECS_UNITS-1:0] dispatch,
   output logic [CECS_UNITS-1:0] done,
   output logic                  load,
   output logic [CECS_INC_W-1:0] fp_byp,
   output logic [CECS_INC_W-1:0] simd_byp
);
   logic [4:0]            left;
   logic [2:0]            idle;
   logic [CECS_UNITS-1:0] pend;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         {page_walk, fp_uop, assist, mul, div, div_busy, dispatch, done, load} <= '0;
         {fp_byp, simd_byp, left, idle, pend} <= '0;
      end else begin
         {simd_byp, fp_byp, div, mul, assist, fp_uop, page_walk} <= rnd[23:0];
         // sparse dispatch so that divider-only cycles really occur
         dispatch <= rnd[27:24] & {4{rnd[28] & rnd[29]}};
         // a unit only reports completion of work it actually took
         // a completion already reported is not reported again
         done     <= pend & ~done & rnd[31:28];
         pend     <= (pend & ~done) | dispatch;
         load     <= rnd[30] & rnd[29] & rnd[9];
         div_busy <= left != 5'h0;
         if (left != 5'h0) begin
            left <= left - 5'h1;
            idle <= 3'h0;
         end else if (idle != 3'h7) begin
            idle <= idle + 3'h1;
         end else if (rnd[2]) begin
            left <= {1'b1, rnd[6:3]};
         end
      end
   end
endmodule

// [testbench/cecs_top_properties.sv]
// timing relations between selection, occurrence inputs and counter outputs
// assumes it is bound to the top module and sees only its ports
`timescale 1ns/1ps
module cecs_top_properties
   import cecs_pkg::*;
(
   input wire logic                  CLK,
   input wire logic                  RESET,
   input wire cecs_sel_s             SELECT0,
   input wire cecs_sel_s             SELECT1,
   input wire logic [1:0]            COUNT_ENABLE,
   input wire logic [1:0]            COUNT_CLEAR,
   input wire logic                  PAGE_WALK_ACTIVE,
   input wire logic [CECS_INC_W-1:0] FP_UOP_EXECUTED,
   input wire cecs_assist_s          ASSIST,
   input wire logic [CECS_INC_W-1:0] MUL_EXECUTED,
   input wire logic                  DIV_BUSY,
   input wire logic [CECS_UNITS-1:0] UNIT_DISPATCH,
   input wire logic                  LOAD_DISPATCH,
   input wire logic [CECS_CNT_W-1:0] COUNT0,
   input wire logic [CECS_CNT_W-1:0] COUNT1,
   input wire logic [1:0]            SELECT_SUPPORTED
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RESET);
   wire logic       go0 = COUNT_ENABLE[0] & ~COUNT_CLEAR[0];
   wire logic       go1 = COUNT_ENABLE[1] & ~COUNT_CLEAR[1];
   wire logic [2:0] ast = 3'(ASSIST.vec_valid & ((ASSIST.vec_denormal_in
      & ~ASSIST.denormals_as_zero_flag) | (ASSIST.vec_underflow
      & ~ASSIST.flush_underflow_to_zero_flag)))
      + 3'(ASSIST.stk_nan_denormal_load | ASSIST.stk_div_by_zero | ASSIST.stk_underflow);

   property p_pw;
      go0 && SELECT0 == 16'h0c02 && PAGE_WALK_ACTIVE |=> COUNT0 == $past(COUNT0) + 40'h1;
   endproperty
   a_pw: assert property (p_pw) else $error("page walk cycle not counted");
   property p_fpu;
      go0 && SELECT0 == 16'h1000 |=> COUNT0 == $past(COUNT0) + 40'($past(FP_UOP_EXECUTED));
   endproperty
   a_fpu: assert property (p_fpu) else $error("float uop count wrong");
   property p_ast;
      go1 && SELECT1 == 16'h1100 |=> COUNT1 == $past(COUNT1) + 40'($past(ast));
   endproperty
   a_ast: assert property (p_ast) else $error("assist count wrong");
   property p_mul;
      go1 && SELECT1 == 16'h1200 |=> COUNT1 == $past(COUNT1) + 40'($past(MUL_EXECUTED));
   endproperty
   a_mul: assert property (p_mul) else $error("multiply count wrong");
   property p_busy;
      go0 && SELECT0 == 16'h1400 |=> COUNT0 == $past(COUNT0) + 40'($past(DIV_BUSY));
   endproperty
   a_busy: assert property (p_busy) else $error("divider busy count wrong");
   property p_idle;
      go0 && SELECT0 == 16'h1800 && (!DIV_BUSY || UNIT_DISPATCH != 4'h0 || LOAD_DISPATCH)
         |=> $stable(COUNT0);
   endproperty
   a_idle: assert property (p_idle) else $error("divider-only miscounted");
   property p_wrong;
      go0 && SELECT0.code inside {8'h11, 8'h12, 8'h13, 8'h19}
         |=> $stable(COUNT0) && !SELECT_SUPPORTED[0];
   endproperty
   a_wrong: assert property (p_wrong) else $error("event on wrong counter");
   property p_clr;
      COUNT_CLEAR[1] |=> COUNT1 == 40'h0;
   endproperty
   a_clr: assert property (p_clr) else $error("clear did not zero counter 1");
   property p_clr0;
      COUNT_CLEAR[0] |=> COUNT0 == 40'h0;
   endproperty
   a_clr0: assert property (p_clr0) else $error("clear did not zero counter 0");
endmodule

bind cecs_top cecs_top_properties chk_u (.CLK(CLK), .RESET(RESET), .SELECT0(SELECT0),
   .SELECT1(SELECT1), .COUNT_ENABLE(COUNT_ENABLE), .COUNT_CLEAR(COUNT_CLEAR),
   .PAGE_WALK_ACTIVE(PAGE_WALK_ACTIVE), .FP_UOP_EXECUTED(FP_UOP_EXECUTED), .ASSIST(ASSIST),
   .MUL_EXECUTED(MUL_EXECUTED), .DIV_BUSY(DIV_BUSY), .UNIT_DISPATCH(UNIT_DISPATCH),
   .LOAD_DISPATCH(LOAD_DISPATCH), .COUNT0(COUNT0), .COUNT1(COUNT1),
   .SELECT_SUPPORTED(SELECT_SUPPORTED));

// [testbench/testbench.sv]
// self-checking bench: table of selections on both counters, then random traffic
// assumes the core model supplies occurrences; a reference counter predicts each cycle
`timescale 1ns/1ps
module testbench;
   import cecs_pkg::*;
   logic                  clk, reset, pw, busy, ld, idle_ok;
   logic [31:0]           rnd, r;
   cecs_sel_s             sel0, sel1;
   cecs_assist_s          ast;
   logic [1:0]            en, clr, sup_o, es;
   logic [CECS_INC_W-1:0] fpu, mul, div, fpb, smb;
   logic [CECS_UNITS-1:0] disp, done, trk;
   logic [CECS_CNT_W-1:0] c0, c1, e0, e1;
   int                    n_mismatch = 0, check_count = 0, cyc = 0, ldc = 0;
   // the last three codes are unsupported pairs
   logic [15:0]           tbl [12] = '{16'h0c02, 16'h1000, 16'h1100, 16'h1200, 16'h1300,
      16'h1400, 16'h1800, 16'h1900, 16'h1901, 16'h0c01, 16'h1801, 16'h1902};

   cecs_top dut_u (.CLK(clk), .RESET(reset), .SELECT0(sel0), .SELECT1(sel1), .COUNT_ENABLE(en),
      .COUNT_CLEAR(clr), .PAGE_WALK_ACTIVE(pw), .FP_UOP_EXECUTED(fpu), .ASSIST(ast),
      .MUL_EXECUTED(mul), .DIV_EXECUTED(div), .DIV_BUSY(busy), .UNIT_DISPATCH(disp),
      .UNIT_DONE(done), .LOAD_DISPATCH(ld), .FP_BYPASS_PENALTY(fpb), .SIMD_BYPASS_PENALTY(smb),
      .COUNT0(c0), .COUNT1(c1), .SELECT_SUPPORTED(sup_o));
   cecs_core_model core_u (.clk(clk), .rst(reset), .rnd(rnd), .page_walk(pw), .fp_uop(fpu),
      .assist(ast), .mul(mul), .div(div), .div_busy(busy), .dispatch(disp), .done(done),
      .load(ld), .fp_byp(fpb), .simd_byp(smb));

   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return x[0] ? (x >> 1) ^ 32'h80200003 : x >> 1;
   endfunction
   function automatic logic allowed(input int c, input cecs_sel_s s);
      case (s)
         16'h0c02: return 1'b1;
         16'h1000, 16'h1400, 16'h1800: return c == 0;
         16'h1100, 16'h1200, 16'h1300, 16'h1900, 16'h1901: return c == 1;
         default: return 1'b0;
      endcase
   endfunction
   function automatic logic [CECS_CNT_W-1:0] inc(input int c, input cecs_sel_s s);
      logic v;
      v = ast.vec_valid & ((ast.vec_denormal_in & ~ast.denormals_as_zero_flag)
         | (ast.vec_underflow & ~ast.flush_underflow_to_zero_flag));
      if (!allowed(c, s)) return '0;
      case (s.code)
         8'h0c: return CECS_CNT_W'(pw);
         8'h10: return CECS_CNT_W'(fpu);
         8'h11: return CECS_CNT_W'(v) + CECS_CNT_W'(ast.stk_nan_denormal_load
            | ast.stk_div_by_zero | ast.stk_underflow);
         8'h12: return CECS_CNT_W'(mul);
         8'h13: return CECS_CNT_W'(div);
         8'h14: return CECS_CNT_W'(busy);
         8'h18: return CECS_CNT_W'(idle_ok);
         default: return s.umask[0] ? CECS_CNT_W'(smb) : CECS_CNT_W'(fpb);
      endcase
   endfunction

   task automatic chk_cnt(input string nm, input logic [CECS_CNT_W-1:0] ex, got);
      check_count++;
      if (got !== ex) begin
         n_mismatch++;
         $display("BAD %s expected %0h seen %0h", nm, ex, got);
      end
   endtask
   task automatic chk_sup(input logic [1:0] ex, got);
      check_count++;
      if (got !== ex) begin
         n_mismatch++;
         $display("BAD SELECT_SUPPORTED expected %0h seen %0h", ex, got);
      end
   endtask
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   // reference reads inputs before this edge's updates land, as the counters do
   always @(posedge clk) begin
      cyc++;
      if (cyc == 4000) begin
         n_mismatch++;
         final_report();
      end else if (reset) begin
         {e0, e1, es, trk} = '0;
         ldc = 0;
      end else begin
         idle_ok = busy && trk == '0 && disp == '0 && !ld && ldc == 0;
         if (clr[0]) e0 = '0;
         else if (en[0]) e0 += inc(0, sel0);
         if (clr[1]) e1 = '0;
         else if (en[1]) e1 += inc(1, sel1);
         es = {allowed(1, sel1), allowed(0, sel0)};
         trk = busy ? ((trk & ~done) | disp) : '0;
         // the load countdown is dropped as soon as the divider goes idle
         if (!busy) ldc = 0;
         else if (ld) ldc = int'(CECS_LOAD_HIT_CYCLES);
         else if (ldc > 0) ldc = ldc - 1;
      end
   end
   always @(negedge clk) begin
      if (!reset) begin
         chk_cnt("COUNT0", e0, c0);
         chk_cnt("COUNT1", e1, c1);
         chk_sup(es, sup_o);
      end
   end

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   initial begin
      reset = 1'b0;
      rnd = 32'h9e0f452a;
      r = rnd;
      {sel0, sel1, en, clr} = '0;
      #1 reset = 1'b1;
      repeat (8) @(posedge clk);
      reset <= 1'b0;
      for (int i = 0; i < 3000; i++) begin
         @(posedge clk);
         r = lfsr(r);
         rnd <= r;
         if (i < 480) begin
            sel0 <= tbl[i / 40];
            sel1 <= tbl[i / 40];
            en <= 2'h3;
            clr <= 2'h0;
         end else begin
            if (r[7:4] == 4'h0) begin
               sel0 <= tbl[r[15:8] % 12];
               sel1 <= tbl[r[23:16] % 12];
            end
            en <= r[25:24] | r[27:26];
            clr <= {r[31:29] == 3'h0, r[28:26] == 3'h0};
         end
         // a second reset in mid-run
         reset <= (i >= 2000 && i < 2002);
      end
      @(posedge clk);
      final_report();
   end
endmodule
